// ---- design/ufc_regs.svh ----
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH

`define UFC_OFS_FLOW_MODE      8'h00
`define UFC_OFS_RESUME_FIRST   8'h04
`define UFC_OFS_RESUME_SECOND  8'h08
`define UFC_OFS_PAUSE_FIRST    8'h0C
`define UFC_OFS_PAUSE_SECOND   8'h10
`define UFC_OFS_TX_IRQ_THR     8'h14
`define UFC_OFS_RX_IRQ_THR     8'h18
`define UFC_OFS_FLOW_HIGH      8'h1C
`define UFC_OFS_FLOW_LOW       8'h20
`define UFC_OFS_PRESCALE       8'h24
`define UFC_OFS_TURNAROUND     8'h28
`define UFC_OFS_ADV_ONE        8'h2C
`define UFC_OFS_ADV_TWO        8'h30
`define UFC_OFS_STATUS         8'h34

`define UFC_REG_RESET          8'h00

`define UFC_FLOW_AUTO_CTS      7
`define UFC_FLOW_AUTO_RTS      6
`define UFC_ADV1_RX_SENSE      4
`define UFC_ADV1_REMAP         2
`define UFC_ADV1_SOFT_RESET_BIT        1
`define UFC_ADV1_TX_IRQ_MODE   0
`define UFC_ADV1_MASK          8'h17
`define UFC_ADV2_INVERT        5
`define UFC_ADV2_TX_CTRL       4
`define UFC_ADV2_DTR_SEL       3
`define UFC_ADV2_NINE_BIT      0
`define UFC_ADV2_MASK          8'h3F
`define UFC_PRESCALE_MASK      8'h0F

`define UFC_FIFO_DEPTH         8'h80
`define UFC_SRST_CLKS          3'h4

`endif

// ---- design/ufc_pkg.sv ----
package ufc_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ufc_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ufc_wb_rsp_s;

    typedef enum logic [1:0] {
        DIR_RX = 2'b00,
        DIR_TX = 2'b01,
        DIR_WAIT = 2'b10
    } ufc_dir_e;

    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_FIRST = 2'b01,
        FS_SECOND = 2'b10
    } ufc_fsend_e;

endpackage

// ---- design/ufc_ctrl.sv ----
// Operation
// - upper flow bits pick transmitted character pairs
// - lower flow bits pick compared character pairs
// - rx 11, one tx bit: either character matches
// - all four set: send both, need both
// - tx threshold 0 and 1 mean 1
// - rx threshold 0 and 1 mean 1
// - high threshold halts remote, zero is one
// - low threshold resumes remote, zero is one
// - prescaler low nibble, upper nibble reserved
// - after last bit count down, then receive
// - each delay unit lasts one bit time
// - level sensing: no sleep while rx low
// - edge sensing: sleep anyway, wake on toggle
// - remap moves hardware flow to DTR/DSR
// - soft reset bit clears itself when done
// - soft reset lasts four clocks
// - mode 0: below level or empty
// - mode 1: empty needs stop bit gone
// - hard and soft reset clear all registers
// - select bit chooses RTS or DTR direction
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "ufc_regs.svh"

module ufc_ctrl #(
    parameter int FIFO_DEPTH = 128
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ufc_pkg::ufc_wb_req_s wb_req_i,
    output ufc_pkg::ufc_wb_rsp_s wb_rsp_o,
    input wire logic [7:0] rx_fill_i,
    input wire logic [7:0] tx_fill_i,
    input wire logic tx_busy_i,
    input wire logic tx_shift_empty_i,
    input wire logic bit_tick_i,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    output logic [7:0] flow_char_o,
    output logic flow_char_valid_o,
    input wire logic flow_char_ready_i,
    output logic remote_pause_o,
    input wire logic rx_pin_i,
    input wire logic sleep_req_i,
    output logic asleep_o,
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input wire logic modem_rts_n_i,
    input wire logic modem_dtr_n_i,
    output logic rts_n_o,
    output logic dtr_n_o,
    output logic tx_halt_o,
    output logic tx_irq_o,
    output logic rx_irq_o,
    output logic [3:0] prescale_o,
    output logic uart_reset_o
);

    logic [7:0] flow_mode;
    logic [7:0] resume_char_first;
    logic [7:0] resume_char_second;
    logic [7:0] pause_char_first;
    logic [7:0] pause_char_second;
    logic [7:0] tx_irq_threshold;
    logic [7:0] rx_irq_threshold;
    logic [7:0] flow_high_threshold;
    logic [7:0] flow_low_threshold;
    logic [7:0] clock_prescale_value;
    logic [7:0] driver_turnaround_delay;
    logic [7:0] advanced_control_one;
    logic [7:0] advanced_control_two;
    logic [2:0] srst_cnt;
    logic srst_busy;
    logic clear_regs;
    logic ack;
    logic [31:0] rdata;
    logic req_take;
    logic wr;
    logic [7:0] wdat;
    logic [7:0] tx_lvl;
    logic [7:0] rx_lvl;
    logic [7:0] high_lvl;
    logic [7:0] low_lvl;
    logic rx_paused;
    logic sent_paused;
    logic sending_pause;
    ufc_pkg::ufc_fsend_e fsend;
    logic [1:0] tx_mode;
    logic [1:0] rx_mode;
    logic rx_either;
    logic rx_both;
    logic half_resume;
    logic half_pause;
    logic is_resume;
    logic is_pause;
    logic remote_halt;
    ufc_pkg::ufc_dir_e dir_state;
    logic [7:0] dir_cnt;
    logic dir_ctrl;
    logic dir_level;
    logic flow_pin_n;
    logic flow_in_n;
    logic rx_prev;
    logic [7:0] status;

    // zero and one both mean one; values past the fifo depth clamp to it
    function automatic logic [7:0] eff_level(input logic [7:0] v);
        logic [7:0] depth;
        depth = 8'(FIFO_DEPTH);
        if (v == 8'h00) begin
            return 8'h01;
        end
        if (v > depth) begin
            return depth;
        end
        return v;
    endfunction

    assign tx_lvl = eff_level(tx_irq_threshold);
    assign rx_lvl = eff_level(rx_irq_threshold);
    assign high_lvl = eff_level(flow_high_threshold);
    assign low_lvl = eff_level(flow_low_threshold);

    // bus slave: one wait state, ack drops the cycle after it is given
    assign req_take = wb_req_i.cyc && wb_req_i.stb && !ack;
    assign wr = req_take && wb_req_i.we && wb_req_i.sel[0] && !srst_busy;
    assign wdat = wb_req_i.dat[7:0];
    assign wb_rsp_o.ack = ack;
    assign wb_rsp_o.dat = rdata;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= req_take;
        end
    end

    // soft reset: bit reads one while the counter runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srst_cnt <= 3'h0;
        end else if (srst_cnt != 3'h0) begin
            srst_cnt <= srst_cnt - 3'h1;
        end else if (wr && wb_req_i.adr == `UFC_OFS_ADV_ONE && wdat[`UFC_ADV1_SOFT_RESET_BIT]) begin
            srst_cnt <= `UFC_SRST_CLKS;
        end
    end

    assign srst_busy = (srst_cnt != 3'h0);
    assign clear_regs = rst_i || srst_busy;
    assign uart_reset_o = srst_busy;

    always_ff @(posedge clk_i) begin
        if (clear_regs) begin
            flow_mode <= `UFC_REG_RESET;
            resume_char_first <= `UFC_REG_RESET;
            resume_char_second <= `UFC_REG_RESET;
            pause_char_first <= `UFC_REG_RESET;
            pause_char_second <= `UFC_REG_RESET;
            tx_irq_threshold <= `UFC_REG_RESET;
            rx_irq_threshold <= `UFC_REG_RESET;
            flow_high_threshold <= `UFC_REG_RESET;
            flow_low_threshold <= `UFC_REG_RESET;
            clock_prescale_value <= `UFC_REG_RESET;
            driver_turnaround_delay <= `UFC_REG_RESET;
            advanced_control_one <= `UFC_REG_RESET;
            advanced_control_two <= `UFC_REG_RESET;
        end else if (wr) begin
            case (wb_req_i.adr)
                `UFC_OFS_FLOW_MODE: begin
                    flow_mode <= wdat;
                end
                `UFC_OFS_RESUME_FIRST: begin
                    resume_char_first <= wdat;
                end
                `UFC_OFS_RESUME_SECOND: begin
                    resume_char_second <= wdat;
                end
                `UFC_OFS_PAUSE_FIRST: begin
                    pause_char_first <= wdat;
                end
                `UFC_OFS_PAUSE_SECOND: begin
                    pause_char_second <= wdat;
                end
                `UFC_OFS_TX_IRQ_THR: begin
                    tx_irq_threshold <= wdat;
                end
                `UFC_OFS_RX_IRQ_THR: begin
                    rx_irq_threshold <= wdat;
                end
                `UFC_OFS_FLOW_HIGH: begin
                    flow_high_threshold <= wdat;
                end
                `UFC_OFS_FLOW_LOW: begin
                    flow_low_threshold <= wdat;
                end
                `UFC_OFS_PRESCALE: begin
                    clock_prescale_value <= wdat & `UFC_PRESCALE_MASK;
                end
                `UFC_OFS_TURNAROUND: begin
                    driver_turnaround_delay <= wdat;
                end
                `UFC_OFS_ADV_ONE: begin
                    // reset bit is never stored; the counter stands for it
                    advanced_control_one <= wdat & `UFC_ADV1_MASK & 8'hFD;
                end
                `UFC_OFS_ADV_TWO: begin
                    advanced_control_two <= wdat & `UFC_ADV2_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    assign status = {2'h0, srst_busy, asleep_o, remote_halt, rx_paused, rx_irq_o, tx_irq_o};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata <= 32'h00000000;
        end else if (req_take) begin
            case (wb_req_i.adr)
                `UFC_OFS_FLOW_MODE: rdata <= {24'h000000, flow_mode};
                `UFC_OFS_RESUME_FIRST: rdata <= {24'h000000, resume_char_first};
                `UFC_OFS_RESUME_SECOND: rdata <= {24'h000000, resume_char_second};
                `UFC_OFS_PAUSE_FIRST: rdata <= {24'h000000, pause_char_first};
                `UFC_OFS_PAUSE_SECOND: rdata <= {24'h000000, pause_char_second};
                `UFC_OFS_TX_IRQ_THR: rdata <= {24'h000000, tx_irq_threshold};
                `UFC_OFS_RX_IRQ_THR: rdata <= {24'h000000, rx_irq_threshold};
                `UFC_OFS_FLOW_HIGH: rdata <= {24'h000000, flow_high_threshold};
                `UFC_OFS_FLOW_LOW: rdata <= {24'h000000, flow_low_threshold};
                `UFC_OFS_PRESCALE: rdata <= {24'h000000, clock_prescale_value};
                `UFC_OFS_TURNAROUND: rdata <= {24'h000000, driver_turnaround_delay};
                `UFC_OFS_ADV_ONE: rdata <= {24'h000000, advanced_control_one[7:2],
                                            srst_busy, advanced_control_one[0]};
                `UFC_OFS_ADV_TWO: rdata <= {24'h000000, advanced_control_two};
                `UFC_OFS_STATUS: rdata <= {24'h000000, status};
                default: rdata <= 32'h00000000;
            endcase
        end
    end

    assign prescale_o = clock_prescale_value[3:0];

    // receive fill hysteresis
    always_ff @(posedge clk_i) begin
        if (clear_regs) begin
            rx_paused <= 1'b0;
        end else if (rx_fill_i >= high_lvl) begin
            rx_paused <= 1'b1;
        end else if (rx_fill_i <= low_lvl) begin
            rx_paused <= 1'b0;
        end
    end

    assign tx_mode = flow_mode[3:2];
    assign rx_mode = flow_mode[1:0];

    // outgoing pause/resume characters
    always_ff @(posedge clk_i) begin
        if (clear_regs) begin
            fsend <= ufc_pkg::FS_IDLE;
            sent_paused <= 1'b0;
            sending_pause <= 1'b0;
        end else begin
            case (fsend)
                ufc_pkg::FS_IDLE: begin
                    if (tx_mode == 2'b00) begin
                        sent_paused <= rx_paused;
                    end else if (sent_paused != rx_paused) begin
                        sending_pause <= rx_paused;
                        fsend <= ufc_pkg::FS_FIRST;
                    end
                end
                ufc_pkg::FS_FIRST: begin
                    if (flow_char_ready_i) begin
                        if (tx_mode == 2'b11) begin
                            fsend <= ufc_pkg::FS_SECOND;
                        end else begin
                            sent_paused <= sending_pause;
                            fsend <= ufc_pkg::FS_IDLE;
                        end
                    end
                end
                ufc_pkg::FS_SECOND: begin
                    if (flow_char_ready_i) begin
                        sent_paused <= sending_pause;
                        fsend <= ufc_pkg::FS_IDLE;
                    end
                end
                default: begin
                    fsend <= ufc_pkg::FS_IDLE;
                end
            endcase
        end
    end

    assign flow_char_valid_o = (fsend != ufc_pkg::FS_IDLE);
    always_comb begin
        // first slot sends the first pair unless only the second is chosen
        if (fsend == ufc_pkg::FS_FIRST && tx_mode[1]) begin
            flow_char_o = sending_pause ? pause_char_first : resume_char_first;
        end else if (fsend == ufc_pkg::FS_IDLE) begin
            flow_char_o = 8'h00;
        end else begin
            flow_char_o = sending_pause ? pause_char_second : resume_char_second;
        end
    end

    // incoming character compare
    assign rx_either = (rx_mode == 2'b11) && (tx_mode != 2'b11);
    assign rx_both = (rx_mode == 2'b11) && (tx_mode == 2'b11);

    always_comb begin
        is_resume = 1'b0;
        is_pause = 1'b0;
        if (rx_mode == 2'b10) begin
            is_resume = (rx_byte_i == resume_char_first);
            is_pause = (rx_byte_i == pause_char_first);
        end else if (rx_mode == 2'b01) begin
            is_resume = (rx_byte_i == resume_char_second);
            is_pause = (rx_byte_i == pause_char_second);
        end else if (rx_either) begin
            is_resume = (rx_byte_i == resume_char_first) || (rx_byte_i == resume_char_second);
            is_pause = (rx_byte_i == pause_char_first) || (rx_byte_i == pause_char_second);
        end else if (rx_both) begin
            is_resume = half_resume && (rx_byte_i == resume_char_second);
            is_pause = half_pause && (rx_byte_i == pause_char_second);
        end
    end

    always_ff @(posedge clk_i) begin
        if (clear_regs || rx_mode == 2'b00) begin
            remote_halt <= 1'b0;
            half_resume <= 1'b0;
            half_pause <= 1'b0;
        end else if (rx_byte_valid_i) begin
            half_resume <= rx_both && (rx_byte_i == resume_char_first);
            half_pause <= rx_both && (rx_byte_i == pause_char_first);
            if (is_pause) begin
                remote_halt <= 1'b1;
            end else if (is_resume) begin
                remote_halt <= 1'b0;
            end
        end
    end

    assign remote_pause_o = remote_halt;

    // hardware flow pin choice
    assign flow_pin_n = flow_mode[`UFC_FLOW_AUTO_RTS] && rx_paused;
    assign flow_in_n = advanced_control_one[`UFC_ADV1_REMAP] ? dsr_n_i : cts_n_i;
    assign tx_halt_o = remote_halt || (flow_mode[`UFC_FLOW_AUTO_CTS] && flow_in_n);

    // driver turn-around, counted in bit ticks
    always_ff @(posedge clk_i) begin
        if (clear_regs) begin
            dir_state <= ufc_pkg::DIR_RX;
            dir_cnt <= 8'h00;
        end else begin
            case (dir_state)
                ufc_pkg::DIR_RX: begin
                    if (tx_busy_i) begin
                        dir_state <= ufc_pkg::DIR_TX;
                    end
                end
                ufc_pkg::DIR_TX: begin
                    if (tx_shift_empty_i && !tx_busy_i) begin
                        dir_cnt <= driver_turnaround_delay;
                        if (driver_turnaround_delay == 8'h00) begin
                            dir_state <= ufc_pkg::DIR_RX;
                        end else begin
                            dir_state <= ufc_pkg::DIR_WAIT;
                        end
                    end
                end
                ufc_pkg::DIR_WAIT: begin
                    if (tx_busy_i) begin
                        dir_state <= ufc_pkg::DIR_TX;
                    end else if (bit_tick_i) begin
                        dir_cnt <= dir_cnt - 8'h01;
                        if (dir_cnt == 8'h01) begin
                            dir_state <= ufc_pkg::DIR_RX;
                        end
                    end
                end
                default: begin
                    dir_state <= ufc_pkg::DIR_RX;
                end
            endcase
        end
    end

    assign dir_ctrl = advanced_control_two[`UFC_ADV2_NINE_BIT] &&
                      advanced_control_two[`UFC_ADV2_TX_CTRL];
    // receive is low unless inverted
    assign dir_level = (dir_state != ufc_pkg::DIR_RX) ^ advanced_control_two[`UFC_ADV2_INVERT];

    always_ff @(posedge clk_i) begin
        if (clear_regs) begin
            rts_n_o <= 1'b1;
            dtr_n_o <= 1'b1;
        end else if (dir_ctrl && !advanced_control_two[`UFC_ADV2_DTR_SEL]) begin
            rts_n_o <= dir_level;
            dtr_n_o <= advanced_control_one[`UFC_ADV1_REMAP] ? flow_pin_n : modem_dtr_n_i;
        end else if (dir_ctrl) begin
            rts_n_o <= advanced_control_one[`UFC_ADV1_REMAP] ? modem_rts_n_i : flow_pin_n;
            dtr_n_o <= dir_level;
        end else if (advanced_control_one[`UFC_ADV1_REMAP]) begin
            rts_n_o <= modem_rts_n_i;
            dtr_n_o <= flow_pin_n;
        end else begin
            rts_n_o <= flow_pin_n || modem_rts_n_i;
            dtr_n_o <= modem_dtr_n_i;
        end
    end

    // sleep entry and wake
    always_ff @(posedge clk_i) begin
        if (clear_regs) begin
            asleep_o <= 1'b0;
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_pin_i;
            if (!sleep_req_i) begin
                asleep_o <= 1'b0;
            end else if (!asleep_o) begin
                // with rx low, level sensing would wake at once, so it refuses entry
                asleep_o <= advanced_control_one[`UFC_ADV1_RX_SENSE] || rx_pin_i;
            end else if (advanced_control_one[`UFC_ADV1_RX_SENSE]) begin
                asleep_o <= (rx_prev == rx_pin_i);
            end else begin
                asleep_o <= rx_pin_i;
            end
        end
    end

    // fifo level interrupts
    always_ff @(posedge clk_i) begin
        if (clear_regs) begin
            tx_irq_o <= 1'b0;
            rx_irq_o <= 1'b0;
        end else begin
            if (tx_fill_i == 8'h00) begin
                tx_irq_o <= !advanced_control_one[`UFC_ADV1_TX_IRQ_MODE] ||
                            tx_shift_empty_i;
            end else begin
                tx_irq_o <= (tx_fill_i < tx_lvl);
            end
            rx_irq_o <= (rx_fill_i >= rx_lvl);
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_srst_run;
        srst_busy [*4] ##1 !srst_busy;
    endsequence

    property p_ack_pulse;
        req_take |=> ack ##1 !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");

    property p_srst_len;
        $rose(srst_busy) |-> s_srst_run;
    endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");

    property p_srst_clear;
        $fell(srst_busy) |-> tx_irq_threshold == 8'h00 && advanced_control_one == 8'h00
            && flow_mode == 8'h00;
    endproperty
    a_srst_clear: assert property (p_srst_clear) else $error("registers not cleared");

    property p_thr_zero;
        tx_irq_threshold == 8'h00 && tx_fill_i == 8'h01 && !srst_busy |=> !tx_irq_o;
    endproperty
    a_thr_zero: assert property (p_thr_zero) else $error("zero threshold not one");

    property p_clamp;
        rx_irq_threshold > 8'h80 && rx_fill_i == 8'h80 && !srst_busy |=> rx_irq_o;
    endproperty
    a_clamp: assert property (p_clamp) else $error("threshold out of range");

    property p_pause_set;
        rx_fill_i >= high_lvl && !srst_busy |=> rx_paused;
    endproperty
    a_pause_set: assert property (p_pause_set) else $error("no pause at high fill");

    property p_hold;
        rx_paused && rx_fill_i > low_lvl && !srst_busy |=> rx_paused;
    endproperty
    a_hold: assert property (p_hold) else $error("pause released early");

    property p_tsr_mode;
        advanced_control_one[0] && tx_fill_i == 8'h00 && !tx_shift_empty_i && !srst_busy
            |=> !tx_irq_o;
    endproperty
    a_tsr_mode: assert property (p_tsr_mode) else $error("early empty interrupt");

    property p_turn_zero;
        dir_state == ufc_pkg::DIR_TX && tx_shift_empty_i && !tx_busy_i
            && driver_turnaround_delay == 8'h00 && !srst_busy |=> dir_state == ufc_pkg::DIR_RX;
    endproperty
    a_turn_zero: assert property (p_turn_zero) else $error("no turn at zero delay");

    property p_sleep_refuse;
        !asleep_o && !advanced_control_one[4] && !rx_pin_i |=> !asleep_o;
    endproperty
    a_sleep_refuse: assert property (p_sleep_refuse) else $error("slept with rx low");

endmodule

// ---- verif/ufc_remote.sv ----
`timescale 1ns/10ps
// remote station: takes flow chars one cycle late, like a slow peer
module ufc_remote (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] char_i,
    input wire logic valid_i,
    output logic ready_o,
    output logic [7:0] last_o,
    output logic [3:0] cnt_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            last_o <= 8'h00;
            cnt_o <= 4'h0;
        end else begin
            ready_o <= valid_i & ~ready_o;
            if (valid_i & ready_o) begin
                last_o <= char_i;
                cnt_o <= cnt_o + 4'h1;
            end
        end
    end
endmodule

// ---- verif/tb_uart_flow_trigger_rs485_ctrl.sv ----
`timescale 1ns/10ps
`include "ufc_regs.svh"
module tb_uart_flow_trigger_rs485_ctrl;
    logic clk_i = 0;
    logic rst_i = 1;
    ufc_pkg::ufc_wb_req_s req = '0;
    ufc_pkg::ufc_wb_rsp_s rsp;
    logic [7:0] rxf = 8'h00, txf = 8'h00, rxb = 8'h00, ch, last;
    logic busy = 0, semp = 0, tick = 0, rxv = 0, pin = 1, slp = 0, dsr = 0;
    logic rdy, fv, pause, slept, rts, dtr, halt, tirq, rirq, ures;
    logic [3:0] pre, pcnt;
    logic [31:0] q;
    logic [7:0] lv[3] = '{8'h00, 8'h80, 8'hFF};
    logic [7:0] lvl[3] = '{8'h01, 8'h80, 8'h80};
    int err_count = 0, tests_run = 0, rcyc = 0, tc = 0, t, k;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tc <= tc + 1;
        tick <= (tc % 4 == 3);
        if (ures) rcyc <= rcyc + 1;
    end
    ufc_ctrl i_ufc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .rx_fill_i(rxf), .tx_fill_i(txf), .tx_busy_i(busy), .tx_shift_empty_i(semp),
        .bit_tick_i(tick), .rx_byte_valid_i(rxv), .rx_byte_i(rxb), .flow_char_o(ch),
        .flow_char_valid_o(fv), .flow_char_ready_i(rdy), .remote_pause_o(pause),
        .rx_pin_i(pin), .sleep_req_i(slp), .asleep_o(slept), .cts_n_i(1'b1), .dsr_n_i(dsr),
        .modem_rts_n_i(1'b1), .modem_dtr_n_i(1'b1), .rts_n_o(rts), .dtr_n_o(dtr),
        .tx_halt_o(halt), .tx_irq_o(tirq), .rx_irq_o(rirq), .prescale_o(pre),
        .uart_reset_o(ures));
    ufc_remote i_ufc_remote (.clk_i(clk_i), .rst_i(rst_i), .char_i(ch), .valid_i(fv),
        .ready_o(rdy), .last_o(last), .cnt_o(pcnt));
    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        q = rsp.dat;
        req <= '0;
        tmo(n >= 20);
    endtask
    task automatic tmo(input bit c);
        if (c) begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %0h", a), q, {24'h0, e});
    endtask
    task automatic wait_char(input logic [3:0] n);
        for (k = 0; k < 30 && pcnt !== n; k++) @(posedge clk_i);
        chk("char count", pcnt, n);
        tmo(pcnt !== n);
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge clk_i);
        rxv <= 1'b1;
        rxb <= b;
        @(posedge clk_i);
        rxv <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a <= 'h30; a += 4) rd(a[7:0], 8'h00);
        bus(1'b1, 8'h40, 8'h5A);
        rd(8'h40, 8'h00);
        bus(1'b1, `UFC_OFS_PRESCALE, 8'hFF);
        rd(`UFC_OFS_PRESCALE, 8'h0F);
        chk("prescale", pre, 4'hF);
        foreach (lv[i]) begin
            bus(1'b1, `UFC_OFS_RX_IRQ_THR, lv[i]);
            bus(1'b1, `UFC_OFS_TX_IRQ_THR, lv[i]);
            rxf <= lvl[i] - 8'h01;
            txf <= lvl[i] - 8'h01;
            repeat (3) @(posedge clk_i);
            chk("rx_irq low", rirq, 1'b0);
            chk("tx_irq high", tirq, 1'b1);
            rxf <= lvl[i];
            txf <= lvl[i];
            repeat (3) @(posedge clk_i);
            chk("rx_irq high", rirq, 1'b1);
            chk("tx_irq low", tirq, 1'b0);
        end
        rxf <= 8'h00;
        txf <= 8'h00;
        bus(1'b1, `UFC_OFS_ADV_ONE, 8'h01);
        repeat (3) @(posedge clk_i);
        chk("tx_irq wait stop", tirq, 1'b0);
        semp <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("tx_irq stop gone", tirq, 1'b1);
        bus(1'b1, `UFC_OFS_RESUME_FIRST, 8'h11); // payload avoids these
        bus(1'b1, `UFC_OFS_PAUSE_FIRST, 8'h13);
        bus(1'b1, `UFC_OFS_RESUME_SECOND, 8'h21);
        bus(1'b1, `UFC_OFS_PAUSE_SECOND, 8'h23);
        bus(1'b1, `UFC_OFS_FLOW_HIGH, 8'h04);
        bus(1'b1, `UFC_OFS_FLOW_LOW, 8'h02);
        bus(1'b1, `UFC_OFS_FLOW_MODE, 8'h0E);
        rxf <= 8'h04;
        wait_char(4'h1);
        chk("pause first", last, 8'h13);
        wait_char(4'h2);
        chk("pause second", last, 8'h23);
        rxf <= 8'h03;
        repeat (6) @(posedge clk_i);
        chk("hysteresis", pcnt, 4'h2);
        rxf <= 8'h02;
        wait_char(4'h3);
        chk("resume first", last, 8'h11);
        wait_char(4'h4);
        chk("resume second", last, 8'h21);
        send(8'h13);
        chk("paused", {pause, halt}, 2'b11);
        send(8'h21);
        chk("second pair ignored", pause, 1'b1);
        send(8'h11);
        chk("resumed", {pause, halt}, 2'b00);
        bus(1'b1, `UFC_OFS_FLOW_MODE, 8'h0F);
        send(8'h23);
        chk("lone", pause, 1'b0);
        send(8'h13);
        send(8'h23);
        chk("both", pause, 1'b1);
        bus(1'b1, `UFC_OFS_FLOW_MODE, 8'h0B);
        send(8'h21);
        chk("either", pause, 1'b0);
        pin <= 1'b0;
        slp <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("no sleep rx low", slept, 1'b0);
        pin <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("sleep", slept, 1'b1);
        pin <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("wake low", slept, 1'b0);
        bus(1'b1, `UFC_OFS_ADV_ONE, 8'h10);
        repeat (3) @(posedge clk_i);
        chk("edge sleep", slept, 1'b1);
        pin <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("edge wake", slept, 1'b0);
        slp <= 1'b0;
        bus(1'b1, `UFC_OFS_ADV_TWO, 8'h11);
        bus(1'b1, `UFC_OFS_TURNAROUND, 8'h02);
        busy <= 1'b1;
        semp <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("drive dir", rts, 1'b1);
        for (k = 0; k < 8 && tick !== 1'b1; k++) @(posedge clk_i);
        tmo(k >= 8);
        busy <= 1'b0;
        semp <= 1'b1;
        t = 0;
        for (k = 0; k < 60 && rts !== 1'b0; k++) begin
            @(posedge clk_i);
            if (tick) t++;
        end
        tmo(k >= 60);
        chk("turnaround ticks", t, 2);
        bus(1'b1, `UFC_OFS_ADV_ONE, 8'h02);
        repeat (8) @(posedge clk_i);
        chk("reset length", rcyc, 4);
        rd(`UFC_OFS_ADV_ONE, 8'h00);
        rd(`UFC_OFS_PRESCALE, 8'h00);
        rd(`UFC_OFS_FLOW_HIGH, 8'h00);
        rxf <= 8'h00;
        bus(1'b1, `UFC_OFS_FLOW_MODE, 8'hC0);
        bus(1'b1, `UFC_OFS_ADV_ONE, 8'h04);
        @(posedge clk_i);
        chk("remap", {dtr, rts, halt}, 3'b010);
        dsr <= 1'b1;
        @(posedge clk_i);
        chk("dsr", halt, 1'b1);
        complete_run();
    end
endmodule
